// ### core/rpg_reset_gate.sv
/*
 * rpg_reset_gate: supervisory glue between the analog monitors and the logic core.
 * Forms the core reset, carries the monitor flags, gates the five high-side
 * pre-driver commands and holds the protection config and status registers.
 * Assumes every input is synchronous to core_clk_i and the register master
 * uses single-cycle strobes with read data expected one cycle later.
 */
// Implementation choice: strobed register access.
// Overview of operation
// - bandgap good output is high only while the reference is in range.
// - serial interface reset output stays low while that block is in reset.
// - pin reset signal follows the external active-low reset pin, never latched.
// - core reset is the AND of power-on, serial and pin resets.
// - 5 V undervoltage flag is high below lockout, sent to all five high-side pre-drivers.
// - pre-driver supply undervoltage flag is high below lockout, sent to all pre-drivers.
// - external pre-driver supply select disables the internal regulator.
// - boost comparator output goes to the logic core as one feedback bit.
// - boost monitor comparator takes an 8-bit value.
// - config bit shuts down all high sides on boost undervoltage in UV mode.
// - boost undervoltage flag tracks comparator only in UV mode, readable in status.
// - boost monitor mode bit selects divider ratio, 1/4 or 1/32.
// - over-temperature flag asserts above threshold and shows in status.
// - logic core gives one drive request per high side, five in all.
// - each gate command combines request, both undervoltages and drive enable.
module rpg_reset_gate
    import rpg_pkg::*;
(
    input wire logic core_clk_i, // 20 MHz system clock
    input wire logic rst_i, // async reset, active high
    // register port
    input wire logic [RPG_ADDR_W-1:0] reg_addr_i, // register address
    input wire logic [RPG_DATA_W-1:0] reg_wdata_i, // write data
    input wire logic reg_wr_i, // write strobe
    input wire logic reg_rd_i, // read strobe
    output logic [RPG_DATA_W-1:0] reg_rdata_o, // read data, cycle after strobe
    output logic irq_o, // level interrupt
    // analog monitors and reset sources
    input wire logic bandgap_in_range_i, // reference within expected range
    input wire logic supply_power_on_reset_n_i, // core supply power-on reset
    input wire logic serial_iface_in_reset_i, // serial block held in reset
    input wire logic external_reset_pin_n_i, // external reset pin level
    input wire logic five_volt_below_uvlo_i, // 5 V supply comparator
    input wire logic predrive_below_uvlo_i, // pre-driver supply comparator
    input wire logic predrive_ext_select_i, // external pre-driver supply chosen
    input wire logic boost_cmp_i, // boost comparator, high when below threshold
    input wire logic over_temp_cmp_i, // temperature comparator
    input wire logic drive_enable_i, // drive enable pin level
    // logic core side
    input wire logic [RPG_NUM_HS-1:0] hs_drive_req_i, // high-side drive requests
    output logic bandgap_good_o, // reference good
    output logic serial_iface_reset_n_o, // serial interface reset, low active
    output logic pin_reset_follow_n_o, // copy of the reset pin
    output logic core_reset_n_o, // logic core reset, low active
    output logic logic_supply_undervoltage_o, // 5 V undervoltage flag
    output logic predrive_supply_undervoltage_o, // pre-driver undervoltage flag
    output logic predrive_regulator_disable_o, // internal regulator off
    output logic boost_fbk_o, // boost comparator feedback
    output logic boost_undervoltage_o, // boost undervoltage flag
    output logic over_temp_o, // over-temperature flag
    output logic [RPG_DAC_W-1:0] boost_dac_value_o, // boost comparator value
    output logic boost_div_quarter_o, // 1: divider 1/4, 0: divider 1/32
    output logic [RPG_NUM_HS-1:0] hs_gate_cmd_o // effective high-side commands
);

    typedef struct packed {
        logic pin_follow_n;
        logic core_rst_n;
        logic spi_rst_n;
        logic bg_good;
        logic uv_logic;
        logic uv_predrv;
        logic reg_dis;
        logic boost_fbk;
        logic boost_uv;
        logic over_temp;
        logic drive_en;
        logic boost_kill;
        logic [RPG_NUM_HS-1:0] req;
        logic [RPG_DATA_W-1:0] cfg;
        logic [RPG_NUM_EVT-1:0] flags_prev;
        logic [RPG_NUM_EVT-1:0] evt_sts;
        logic [RPG_NUM_EVT-1:0] evt_mask;
        logic irq;
        logic [RPG_DATA_W-1:0] rdata;
    } rpg_state_s;

    rpg_state_s st_r;
    rpg_state_s st_nxt;

    logic uv_mode;
    logic core_run;
    logic [RPG_NUM_EVT-1:0] flags_now;
    logic [RPG_NUM_EVT-1:0] evt_hit;
    logic [RPG_NUM_EVT-1:0] evt_clr;
    logic [RPG_DATA_W-1:0] drv_sts_word;
    logic wr_cfg;
    logic wr_evt;
    logic wr_mask;

    // mode and run qualifiers shared by several sections
    assign uv_mode = st_r.cfg[RPG_CFG_UV_MODE_BIT];
    assign core_run = st_r.core_rst_n;

    // status image in the driver status layout
    always_comb begin
        flags_now = '0;
        flags_now[RPG_STS_BOOST_UV_BIT] = st_r.boost_uv;
        flags_now[RPG_STS_OVER_TEMP_BIT] = st_r.over_temp;
        flags_now[RPG_STS_LOGIC_UV_BIT] = st_r.uv_logic;
        flags_now[RPG_STS_PREDRV_UV_BIT] = st_r.uv_predrv;
        // inverted so losing the reference is the event
        flags_now[RPG_STS_BANDGAP_BIT] = ~st_r.bg_good;
    end

    always_comb begin
        drv_sts_word = '0;
        drv_sts_word[RPG_STS_BOOST_UV_BIT] = st_r.boost_uv;
        drv_sts_word[RPG_STS_OVER_TEMP_BIT] = st_r.over_temp;
        drv_sts_word[RPG_STS_LOGIC_UV_BIT] = st_r.uv_logic;
        drv_sts_word[RPG_STS_PREDRV_UV_BIT] = st_r.uv_predrv;
        drv_sts_word[RPG_STS_BANDGAP_BIT] = st_r.bg_good;
    end

    // rising edges of the flag image are the interrupt events
    assign evt_hit = flags_now & ~st_r.flags_prev;

    // address decode for writes
    always_comb begin
        wr_cfg = 1'b0;
        wr_evt = 1'b0;
        wr_mask = 1'b0;
        if (reg_wr_i && reg_addr_i == RPG_OFS_CFG) begin
            wr_cfg = 1'b1;
        end else if (reg_wr_i && reg_addr_i == RPG_OFS_IRQ_STS) begin
            wr_evt = 1'b1;
        end else if (reg_wr_i && reg_addr_i == RPG_OFS_IRQ_MASK) begin
            wr_mask = 1'b1;
        end
    end

    assign evt_clr = wr_evt ? reg_wdata_i[RPG_NUM_EVT-1:0] : '0;

    always_comb begin
        st_nxt = st_r;

        // reset formation
        st_nxt.pin_follow_n = external_reset_pin_n_i;
        st_nxt.spi_rst_n = ~serial_iface_in_reset_i;
        st_nxt.core_rst_n = supply_power_on_reset_n_i & ~serial_iface_in_reset_i
            & external_reset_pin_n_i;

        // analog monitor flags
        st_nxt.bg_good = bandgap_in_range_i;
        st_nxt.reg_dis = predrive_ext_select_i;
        st_nxt.boost_fbk = boost_cmp_i;
        st_nxt.drive_en = drive_enable_i;

        // flags are forced clear while the core is held in reset
        if (core_run) begin
            st_nxt.uv_logic = five_volt_below_uvlo_i;
            st_nxt.uv_predrv = predrive_below_uvlo_i;
            st_nxt.over_temp = over_temp_cmp_i;
            // only meaningful in UV monitoring mode, else held low
            st_nxt.boost_uv = boost_cmp_i & uv_mode;
        end else begin
            st_nxt.uv_logic = 1'b0;
            st_nxt.uv_predrv = 1'b0;
            st_nxt.over_temp = 1'b0;
            st_nxt.boost_uv = 1'b0;
        end

        // boost shutdown of every high side
        st_nxt.boost_kill = st_r.cfg[RPG_CFG_SHUTDOWN_EN_BIT] & uv_mode
            & st_r.boost_uv;

        // drive requests, one per high side
        if (core_run) begin
            st_nxt.req = hs_drive_req_i;
        end else begin
            st_nxt.req = '0;
        end

        // configuration register
        if (wr_cfg) begin
            st_nxt.cfg = reg_wdata_i & RPG_CFG_WMASK;
        end

        // sticky events: a new event wins over a clear in the same cycle
        st_nxt.flags_prev = flags_now;
        if (core_run) begin
            st_nxt.evt_sts = (st_r.evt_sts & ~evt_clr) | evt_hit;
        end else begin
            st_nxt.evt_sts = RPG_EVT_RST;
        end
        if (wr_mask) begin
            st_nxt.evt_mask = reg_wdata_i[RPG_NUM_EVT-1:0];
        end
        st_nxt.irq = |(st_nxt.evt_sts & st_nxt.evt_mask);

        // read data stands only in the cycle after the strobe
        st_nxt.rdata = RPG_RDATA_IDLE;
        if (reg_rd_i && reg_addr_i == RPG_OFS_CFG) begin
            st_nxt.rdata = st_r.cfg;
        end else if (reg_rd_i && reg_addr_i == RPG_OFS_DRV_STS) begin
            st_nxt.rdata = drv_sts_word;
        end else if (reg_rd_i && reg_addr_i == RPG_OFS_IRQ_STS) begin
            st_nxt.rdata = {{(RPG_DATA_W-RPG_NUM_EVT){1'b0}}, st_r.evt_sts};
        end else if (reg_rd_i && reg_addr_i == RPG_OFS_IRQ_MASK) begin
            st_nxt.rdata = {{(RPG_DATA_W-RPG_NUM_EVT){1'b0}}, st_r.evt_mask};
        end
    end

    // reset values: core held in reset, reset copies read low (asserted) and flags clear
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r.pin_follow_n <= 1'b0;
            st_r.core_rst_n <= 1'b0;
            st_r.spi_rst_n <= 1'b0;
            st_r.bg_good <= 1'b0;
            st_r.uv_logic <= 1'b0;
            st_r.uv_predrv <= 1'b0;
            st_r.reg_dis <= 1'b0;
            st_r.boost_fbk <= 1'b0;
            st_r.boost_uv <= 1'b0;
            st_r.over_temp <= 1'b0;
            st_r.drive_en <= 1'b0;
            st_r.boost_kill <= 1'b0;
            st_r.req <= '0;
            st_r.cfg <= RPG_CFG_RST;
            // all-ones avoids a spurious bandgap event right after reset
            st_r.flags_prev <= '1;
            st_r.evt_sts <= RPG_EVT_RST;
            st_r.evt_mask <= RPG_MASK_RST;
            st_r.irq <= 1'b0;
            st_r.rdata <= RPG_RDATA_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // high-side gating, one registered stage per channel
    genvar gi;
    generate
        for (gi = 0; gi < RPG_NUM_HS; gi++) begin : g_hs
            rpg_hs_gate #(
                .RST_VAL(1'b0)
            ) u_gate (
                .core_clk_i(core_clk_i),
                .rst_i(rst_i),
                .drive_req_i(st_r.req[gi]),
                .logic_uv_i(st_r.uv_logic),
                .predrv_uv_i(st_r.uv_predrv),
                .drive_en_i(st_r.drive_en),
                .boost_kill_i(st_r.boost_kill),
                .gate_cmd_o(hs_gate_cmd_o[gi])
            );
        end
    endgenerate

    assign reg_rdata_o = st_r.rdata;
    assign irq_o = st_r.irq;
    assign bandgap_good_o = st_r.bg_good;
    assign serial_iface_reset_n_o = st_r.spi_rst_n;
    assign pin_reset_follow_n_o = st_r.pin_follow_n;
    assign core_reset_n_o = st_r.core_rst_n;
    assign logic_supply_undervoltage_o = st_r.uv_logic;
    assign predrive_supply_undervoltage_o = st_r.uv_predrv;
    assign predrive_regulator_disable_o = st_r.reg_dis;
    assign boost_fbk_o = st_r.boost_fbk;
    assign boost_undervoltage_o = st_r.boost_uv;
    assign over_temp_o = st_r.over_temp;
    assign boost_dac_value_o = st_r.cfg[RPG_CFG_DAC_LSB +: RPG_DAC_W];
    assign boost_div_quarter_o = st_r.cfg[RPG_CFG_UV_MODE_BIT];

endmodule

// ### core/rpg_pkg.sv
/*
 * rpg_pkg: shared constants for the reset and high-side pre-driver gating block.
 * Assumes a 9-bit register address space and 16-bit register data on a plain port.
 */
package rpg_pkg;

    // register port geometry
    localparam int unsigned RPG_ADDR_W = 9;
    localparam int unsigned RPG_DATA_W = 16;

    // high-side channel count and boost comparator value width
    localparam int unsigned RPG_NUM_HS = 5;
    localparam int unsigned RPG_DAC_W = 8;

    // register offsets
    localparam logic [8:0] RPG_OFS_CFG = 9'h1c5;
    localparam logic [8:0] RPG_OFS_DRV_STS = 9'h1d2;
    localparam logic [8:0] RPG_OFS_IRQ_STS = 9'h1d3;
    localparam logic [8:0] RPG_OFS_IRQ_MASK = 9'h1d4;

    // driver_protection_config fields
    localparam int unsigned RPG_CFG_SHUTDOWN_EN_BIT = 0;
    localparam int unsigned RPG_CFG_UV_MODE_BIT = 1;
    localparam int unsigned RPG_CFG_DAC_LSB = 8;
    localparam logic [15:0] RPG_CFG_WMASK = 16'hff03;
    localparam logic [15:0] RPG_CFG_RST = 16'h0000;

    // driver_fault_status fields, also the layout of the event status and mask
    localparam int unsigned RPG_STS_BOOST_UV_BIT = 0;
    localparam int unsigned RPG_STS_OVER_TEMP_BIT = 1;
    localparam int unsigned RPG_STS_LOGIC_UV_BIT = 2;
    localparam int unsigned RPG_STS_PREDRV_UV_BIT = 3;
    localparam int unsigned RPG_STS_BANDGAP_BIT = 4;
    localparam int unsigned RPG_NUM_EVT = 5;
    localparam logic [4:0] RPG_EVT_RST = 5'h00;
    localparam logic [4:0] RPG_MASK_RST = 5'h00;

    // unmapped reads
    localparam logic [15:0] RPG_RDATA_IDLE = 16'h0000;

endpackage

// ### core/rpg_hs_gate.sv
/*
 * rpg_hs_gate: one high-side pre-driver command stage with a registered output.
 * Assumes all inputs are already registered and synchronous to core_clk_i.
 */
module rpg_hs_gate #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic core_clk_i, // system clock
    input wire logic rst_i, // async reset, active high
    input wire logic drive_req_i, // request from the logic core
    input wire logic logic_uv_i, // 5 V supply undervoltage
    input wire logic predrv_uv_i, // pre-driver supply undervoltage
    input wire logic drive_en_i, // clock-qualified drive enable
    input wire logic boost_kill_i, // boost undervoltage shutdown
    output logic gate_cmd_o // effective gate command
);

    typedef struct packed {
        logic cmd;
    } rpg_gate_s;

    rpg_gate_s st_r;
    rpg_gate_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        // any undervoltage or a dropped enable forces the gate off
        st_nxt.cmd = drive_req_i & ~logic_uv_i & ~predrv_uv_i & drive_en_i & ~boost_kill_i;
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r.cmd <= RST_VAL;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign gate_cmd_o = st_r.cmd;

endmodule

// ### dv/rpg_reset_gate_asserts.sv
/*
 * rpg_reset_gate_asserts: port-level checks of rpg_reset_gate.
 * Assumes it is bound onto the design top; one clock domain.
 */
module rpg_reset_gate_asserts
    import rpg_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [RPG_ADDR_W-1:0] reg_addr_i,
    input wire logic [RPG_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [RPG_DATA_W-1:0] reg_rdata_o,
    input wire logic irq_o,
    input wire logic bandgap_in_range_i,
    input wire logic supply_power_on_reset_n_i,
    input wire logic serial_iface_in_reset_i,
    input wire logic external_reset_pin_n_i,
    input wire logic five_volt_below_uvlo_i,
    input wire logic predrive_below_uvlo_i,
    input wire logic predrive_ext_select_i,
    input wire logic boost_cmp_i,
    input wire logic over_temp_cmp_i,
    input wire logic drive_enable_i,
    input wire logic [RPG_NUM_HS-1:0] hs_drive_req_i,
    input wire logic bandgap_good_o,
    input wire logic serial_iface_reset_n_o,
    input wire logic pin_reset_follow_n_o,
    input wire logic core_reset_n_o,
    input wire logic logic_supply_undervoltage_o,
    input wire logic predrive_supply_undervoltage_o,
    input wire logic predrive_regulator_disable_o,
    input wire logic boost_fbk_o,
    input wire logic boost_undervoltage_o,
    input wire logic over_temp_o,
    input wire logic [RPG_DAC_W-1:0] boost_dac_value_o,
    input wire logic boost_div_quarter_o,
    input wire logic [RPG_NUM_HS-1:0] hs_gate_cmd_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // shutdown enable is not visible at the ports, so shadow it from writes
    logic live_r;
    logic sd_en_r;
    wire logic core_ok = supply_power_on_reset_n_i && !serial_iface_in_reset_i && external_reset_pin_n_i;
    wire logic drv_ok = !five_volt_below_uvlo_i && !predrive_below_uvlo_i && drive_enable_i;
    wire logic [RPG_NUM_HS-1:0] want = hs_drive_req_i & {RPG_NUM_HS{drv_ok}};
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            live_r <= 1'b0;
            sd_en_r <= 1'b0;
        end else begin
            live_r <= 1'b1;
            if (reg_wr_i && reg_addr_i == RPG_OFS_CFG) begin
                sd_en_r <= reg_wdata_i[RPG_CFG_SHUTDOWN_EN_BIT];
            end
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    AST_BG: assert property (live_r |-> bandgap_good_o == $past(bandgap_in_range_i))
        else $error("bandgap good does not follow the reference");
    AST_SPI: assert property (live_r |-> serial_iface_reset_n_o == !$past(serial_iface_in_reset_i))
        else $error("serial reset output wrong");
    AST_PIN: assert property (live_r |-> pin_reset_follow_n_o == $past(external_reset_pin_n_i))
        else $error("pin reset copy wrong");
    AST_CORE: assert property (live_r |-> core_reset_n_o == $past(core_ok))
        else $error("core reset is not the and of its sources");
    AST_UV5: assert property (core_reset_n_o && $past(core_reset_n_o) |->
        logic_supply_undervoltage_o == $past(five_volt_below_uvlo_i))
        else $error("5 V undervoltage flag wrong");
    AST_UVP: assert property (core_reset_n_o && $past(core_reset_n_o) |->
        predrive_supply_undervoltage_o == $past(predrive_below_uvlo_i))
        else $error("pre-driver undervoltage flag wrong");
    AST_REGDIS: assert property (live_r |-> predrive_regulator_disable_o == $past(predrive_ext_select_i))
        else $error("regulator disable wrong");
    AST_FBK: assert property (live_r |-> boost_fbk_o == $past(boost_cmp_i))
        else $error("boost feedback wrong");
    AST_BUV: assert property (core_reset_n_o && $past(core_reset_n_o) |->
        boost_undervoltage_o == ($past(boost_cmp_i) && $past(boost_div_quarter_o)))
        else $error("boost undervoltage flag wrong");
    AST_CFG: assert property (reg_wr_i && reg_addr_i == RPG_OFS_CFG |=>
        {boost_dac_value_o, 6'h00, boost_div_quarter_o, 1'b0} == ($past(reg_wdata_i) & 16'hff02))
        else $error("config outputs do not follow the write");
    AST_STS: assert property ($past(reg_rd_i) && $past(reg_addr_i) == RPG_OFS_DRV_STS |->
        reg_rdata_o[1:0] == {$past(over_temp_o), $past(boost_undervoltage_o)})
        else $error("status read does not show the flags");
    AST_GATE: assert property (core_reset_n_o && $past(core_reset_n_o) &&
        $past(core_reset_n_o, 2) && !$past(boost_undervoltage_o) && !$past(boost_undervoltage_o, 2) |->
        hs_gate_cmd_o == $past(want, 2))
        else $error("gate command not request and enable without undervoltage");
    // config must already have stood a cycle, since the kill stage lags a config write by one edge
    AST_KILL: assert property (sd_en_r && boost_div_quarter_o && boost_undervoltage_o &&
        $past(boost_undervoltage_o) && $past(sd_en_r) && $past(boost_div_quarter_o) |=> hs_gate_cmd_o == '0)
        else $error("high sides not shut down on boost undervoltage");
    AST_CRST: assert property ((!core_reset_n_o)[*3] |=>
        hs_gate_cmd_o == '0 && !over_temp_o && !boost_undervoltage_o && !logic_supply_undervoltage_o)
        else $error("core reset does not quiet requests and flags");
    CV_KILL: cover property (sd_en_r && boost_undervoltage_o);
    CV_IRQ: cover property (irq_o);
    CV_CRST: cover property (live_r && !core_reset_n_o);
endmodule

bind rpg_reset_gate rpg_reset_gate_asserts u_ast (.*);

// ### dv/rpg_core_model.sv
/*
 * rpg_core_model: logic-core side issuing the five high-side drive requests.
 * Assumes the bench supplies the wanted pattern and the block's core reset.
 */
module rpg_core_model
    import rpg_pkg::*;
(
    input wire logic core_clk_i, // system clock
    input wire logic rst_i, // async reset, active high
    input wire logic core_reset_n_i, // core reset from the block
    input wire logic [RPG_NUM_HS-1:0] pattern_i, // wanted requests
    output logic [RPG_NUM_HS-1:0] req_o // one request per high side
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_o <= '0;
        end else begin
            req_o <= core_reset_n_i ? pattern_i : '0;
        end
    end
endmodule

// ### dv/tb.sv
/*
 * tb: self-checking bench for rpg_reset_gate with the logic-core model.
 * Assumes the package, the checker and the model are compiled first.
 */
module tb
    import rpg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [8:0] reg_addr_i = '0;
    logic [15:0] reg_wdata_i = '0, reg_rdata_o, d, w;
    logic bandgap_in_range_i = 1'b1, supply_power_on_reset_n_i = 1'b1, serial_iface_in_reset_i = 1'b0;
    logic external_reset_pin_n_i = 1'b1, five_volt_below_uvlo_i = 1'b0, predrive_below_uvlo_i = 1'b0;
    logic predrive_ext_select_i = 1'b0, boost_cmp_i = 1'b0, over_temp_cmp_i = 1'b0, drive_enable_i = 1'b1;
    logic irq_o, bandgap_good_o, serial_iface_reset_n_o, pin_reset_follow_n_o, core_reset_n_o;
    logic logic_supply_undervoltage_o, predrive_supply_undervoltage_o, predrive_regulator_disable_o;
    logic boost_fbk_o, boost_undervoltage_o, over_temp_o, boost_div_quarter_o;
    logic [7:0] boost_dac_value_o;
    logic [4:0] hs_drive_req_i, hs_gate_cmd_o, pattern = '0, p;
    logic [9:0] v;
    int n_mismatch = 0, check_count = 0, seed;
    localparam logic [9:0] OK = 10'h341;
    always #25 core_clk_i = ~core_clk_i;
    rpg_reset_gate uut (.*);
    rpg_core_model u_core (.core_clk_i(core_clk_i), .rst_i(rst_i), .core_reset_n_i(core_reset_n_o),
        .pattern_i(pattern), .req_o(hs_drive_req_i));
    function automatic logic [4:0] exp_gate(logic [4:0] r, logic [9:0] s);
        return (s[5] || s[4] || !s[0]) ? 5'h00 : r;
    endfunction
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [8:0] a, logic [15:0] x);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= x;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(logic [8:0] a);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    // order: bandgap, por, serial, pin, uv5, uvp, ext, boost, temp, enable
    task automatic drv(logic [9:0] s, logic [4:0] r);
        @(posedge core_clk_i);
        {bandgap_in_range_i, supply_power_on_reset_n_i, serial_iface_in_reset_i, external_reset_pin_n_i,
            five_volt_below_uvlo_i, predrive_below_uvlo_i, predrive_ext_select_i, boost_cmp_i,
            over_temp_cmp_i, drive_enable_i} <= s;
        pattern <= r;
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk_i);
        n_mismatch++;
        conclude();
    end
    initial begin
        seed = $urandom(32'h0943);
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        drv(OK, 5'h00);
        settle(3);
        rd(RPG_OFS_CFG);
        chk("cfg reset", RPG_CFG_RST, d);
        rd(RPG_OFS_IRQ_MASK);
        chk("mask reset", 16'(RPG_MASK_RST), d);
        rd(9'h000);
        chk("unmapped read", RPG_RDATA_IDLE, d);
        for (int i = 0; i < 8; i++) begin
            w = (i == 0) ? 16'hffff : 16'($urandom);
            wr(RPG_OFS_CFG, w);
            rd(RPG_OFS_CFG);
            chk("cfg readback", w & RPG_CFG_WMASK, d);
            chk("dac and divider", {w[15:8], 7'h00, w[1]},
                {boost_dac_value_o, 7'h00, boost_div_quarter_o});
        end
        wr(RPG_OFS_CFG, 16'h0000);
        wr(RPG_OFS_DRV_STS, 16'hffff);
        rd(RPG_OFS_DRV_STS);
        chk("status read only", 16'h0010, d);
        for (int i = 0; i < 24; i++) begin
            v = (i == 0) ? OK : ((10'($urandom) & 10'h23f) | 10'h140);
            p = (i == 0) ? 5'h1f : 5'($urandom);
            drv(v, p);
            settle(4);
            chk("gate", 16'(exp_gate(p, v)), 16'(hs_gate_cmd_o));
            chk("flags", 16'({v[9], v[5:1]}),
                16'({bandgap_good_o, logic_supply_undervoltage_o, predrive_supply_undervoltage_o,
                predrive_regulator_disable_o, boost_fbk_o, over_temp_o}));
        end
        wr(RPG_OFS_CFG, 16'h0003);
        drv(OK | 10'h004, 5'h1f);
        settle(5);
        chk("boost shutdown", 16'h0000, 16'(hs_gate_cmd_o));
        rd(RPG_OFS_DRV_STS);
        chk("status boost uv", 16'h0011, d);
        wr(RPG_OFS_CFG, 16'h0001);
        settle(4);
        chk("no shutdown outside uv mode", 16'h001f, 16'(hs_gate_cmd_o));
        chk("boost uv off", 16'h0000, 16'(boost_undervoltage_o));
        wr(RPG_OFS_CFG, 16'h0000);
        drv(OK, 5'h1f);
        settle(3);
        wr(RPG_OFS_IRQ_STS, 16'h001f);
        wr(RPG_OFS_IRQ_MASK, 16'h0002);
        drv(OK | 10'h002, 5'h1f);
        settle(4);
        chk("irq on temp", 16'h0001, 16'(irq_o));
        rd(RPG_OFS_IRQ_STS);
        chk("event status", 16'h0002, d);
        wr(RPG_OFS_IRQ_MASK, 16'h0000);
        settle(2);
        chk("irq masked", 16'h0000, 16'(irq_o));
        wr(RPG_OFS_IRQ_MASK, 16'h0002);
        wr(RPG_OFS_IRQ_STS, 16'h0002);
        settle(2);
        chk("irq cleared", 16'h0000, 16'(irq_o));
        // one bad source at a time; temperature high to prove flags are held clear
        for (int k = 0; k < 3; k++) begin
            v = (k == 0) ? 10'h243 : (k == 1) ? 10'h3c3 : 10'h303;
            drv(v, 5'h1f);
            settle(4);
            chk("core reset", 16'h0000, 16'(core_reset_n_o));
            chk("reset copies", 16'({v[6], !v[7]}),
                16'({pin_reset_follow_n_o, serial_iface_reset_n_o}));
            chk("quiet in core reset", 16'h0000, 16'({hs_gate_cmd_o, over_temp_o}));
            drv(OK, 5'h1f);
            settle(4);
            chk("core released", 16'h0001, 16'(core_reset_n_o));
            rd(RPG_OFS_IRQ_STS);
            chk("events cleared", 16'h0000, d);
        end
        conclude();
    end
endmodule
